// ### rtl/smw_pkg.sv
// Package: shared constants and types of the STOP wake-up controller
package smw_pkg;

    // ****************************************
    // Register map (word offsets as byte addresses)
    // ****************************************
    localparam logic [7:0] SMW_ADDR_CTRL = 8'h00;
    localparam logic [7:0] SMW_ADDR_PSC = 8'h04;
    localparam logic [7:0] SMW_ADDR_OSTS = 8'h08;
    localparam logic [7:0] SMW_ADDR_STAT = 8'h0C;
    localparam logic [7:0] SMW_ADDR_PERIPH = 8'h10;

    // ****************************************
    // Field positions
    // ****************************************
    // Control register
    localparam int SMW_CTRL_STOP = 0;
    localparam int SMW_CTRL_SUB = 1;
    localparam int SMW_CTRL_WT_SUB = 2;
    localparam int SMW_CTRL_T16_WT = 3;
    localparam int SMW_CTRL_T16_EN = 4;
    localparam int SMW_CTRL_T8_EXT = 5;
    localparam int SMW_CTRL_T8_M16 = 6;
    localparam int SMW_CTRL_CSI_EXT = 7;
    localparam int SMW_CTRL_UART_EXT = 8;
    localparam int SMW_CTRL_RTO_T8 = 9;
    localparam int SMW_CTRL_IN_ISR = 10;
    // Power-save control register
    localparam int SMW_PSC_WDT_NM = 0;
    localparam int SMW_PSC_PIN_NM = 1;
    localparam int SMW_PSC_MASK = 2;

    // ****************************************
    // Reset values and widths
    // ****************************************
    localparam int SMW_CNT_W = 16;
    localparam logic [SMW_CNT_W-1:0] SMW_OSTS_RST = 16'h8000;
    localparam logic [10:0] SMW_CTRL_RST = 11'h000;
    localparam logic [2:0] SMW_PSC_RST = 3'h0;
    localparam logic [3:0] SMW_PRIO_RST = 4'h0;
    localparam logic [SMW_CNT_W-1:0] SMW_CNT_ONE = 16'h0001;

    // Wake-up sequencer states
    typedef enum logic [1:0] {
        SMW_RUN = 2'b00,
        SMW_STOP = 2'b01,
        SMW_WAIT = 2'b10
    } smw_state_t;

    // Wake action codes handed to the CPU
    typedef enum logic [1:0] {
        SMW_ACT_NONE = 2'b00,
        SMW_ACT_NEXT = 2'b01,
        SMW_ACT_ACK = 2'b10,
        SMW_ACT_NMI = 2'b11
    } smw_act_t;

endpackage

// ### rtl/smw_stab_cnt.sv
// Oscillation stabilization down-counter
`timescale 1ns/1ps
module smw_stab_cnt
    import smw_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Control
    input wire logic start_i,
    input wire logic [SMW_CNT_W-1:0] load_i,
    // Status
    output logic done_o
);
    logic [SMW_CNT_W-1:0] cnt_q;
    logic busy_q;
    wire logic last;

    assign last = busy_q & (cnt_q <= SMW_CNT_ONE);

    // Restart on every start, even mid-count
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
        end else if (start_i) begin
            cnt_q <= load_i;
            busy_q <= 1'b1;
        end else if (busy_q) begin
            cnt_q <= cnt_q - SMW_CNT_ONE;
            busy_q <= ~last;
        end
    end

    assign done_o = last & ~start_i;
endmodule

// ### rtl/smw_top.sv
// STOP mode wake-up controller top level
//
// Summary of operation
// - Listed NMI, interrupt and reset sources end STOP
// - Resume only after stabilization wait elapses
// - Wake regardless of request priority
// - Lower priority in ISR: wake, keep pending
// - Higher priority or NMI in ISR: acknowledge
// - NMI wake always branches to handler
// - Maskable wake: next instruction unless taken
// - Wake-disable bit set ignores that source
// - Reset wake behaves as ordinary reset
// - Port pins frozen during STOP
// - Internal data preserved through STOP
// - 16-bit timer runs only via subclock watch
// - 8-bit timers on external or match clock
// - Clocked serial port and first UART only on external clocks; second UART and two-wire port stop
// - Real-time output triggers, buffers not reloaded
`timescale 1ns/1ps
module smw_top
    import smw_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // Wake requests
    input wire logic nmi_pin_i,
    input wire logic watchdog2_nonmask_irq_i,
    input wire logic [7:0] ext_pin_irq_i,
    input wire logic [7:0] ext_pin_mask_i,
    input wire logic periph_irq_i,
    input wire logic [3:0] periph_prio_i,
    input wire logic [3:0] ext_prio_i,
    input wire logic rst_pin_i,
    input wire logic watchdog2_reset_i,
    // CPU context
    input wire logic irq_globally_enabled_i,
    input wire logic [3:0] cur_prio_i,
    input wire logic [7:0] port_out_i,
    // CPU control
    output logic cpu_clk_en_o,
    output logic sys_reset_o,
    output logic [1:0] wake_act_o,
    output logic irq_pending_o,
    output logic [7:0] port_pin_o,
    output logic ram_we_en_o,
    // Peripheral clock enables in STOP
    output logic timer16_run_o,
    output logic timer8_run_o,
    output logic clocked_serial_port_run_o,
    output logic first_uart_run_o,
    output logic second_uart_run_o,
    output logic two_wire_port_run_o,
    output logic rto_run_o,
    output logic rto_buffer_load_en_o
);
    // ****************************************
    // Registers and state
    // ****************************************
    smw_state_t state_q, state_d;
    logic [10:0] ctrl_q;
    logic [2:0] psc_q;
    logic [SMW_CNT_W-1:0] osts_q;
    logic [1:0] act_q;
    logic pend_q;
    logic [31:0] rdata_q;
    logic [7:0] port_q;
    logic cpu_en_q;
    logic sysrst_q;
    logic [7:0] run_q;

    smw_wake_if w();

    wire logic stopped;
    wire logic stop_req;
    wire logic start_stab;
    wire logic stab_done;
    wire logic [SMW_CNT_W-1:0] stab_load;
    wire logic sel_ctrl;
    wire logic sel_psc;
    wire logic sel_osts;
    wire logic [31:0] rd_mux;
    wire logic sub;
    wire logic [7:0] run_d;
    smw_act_t act_d;

    // ****************************************
    // Register decode
    // ****************************************
    assign sel_ctrl = wr_i & (addr_i == SMW_ADDR_CTRL);
    assign sel_psc = wr_i & (addr_i == SMW_ADDR_PSC);
    assign sel_osts = wr_i & (addr_i == SMW_ADDR_OSTS);
    assign stop_req = sel_ctrl & wdata_i[SMW_CTRL_STOP]
        & (state_q == SMW_RUN);
    assign sub = ctrl_q[SMW_CTRL_SUB];
    assign stopped = (state_q != SMW_RUN);

    // Read mux; unmapped addresses read zero
    assign rd_mux =
        (addr_i == SMW_ADDR_CTRL) ? {21'h00_0000, ctrl_q} :
        (addr_i == SMW_ADDR_PSC) ? {29'h0000_0000, psc_q} :
        (addr_i == SMW_ADDR_OSTS) ? {16'h0000, osts_q} :
        (addr_i == SMW_ADDR_STAT) ?
            {27'h000_0000, pend_q, act_q, state_q} :
        (addr_i == SMW_ADDR_PERIPH) ? {24'h00_0000, run_q} :
        32'h0000_0000;

    // Software writes only while running; CPU is halted otherwise
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl_q <= SMW_CTRL_RST;
            psc_q <= SMW_PSC_RST;
            osts_q <= SMW_OSTS_RST;
            rdata_q <= 32'h0000_0000;
        end else begin
            if (sel_ctrl) begin
                ctrl_q <= wdata_i[10:0];
            end
            if (sel_psc) begin
                psc_q <= wdata_i[2:0];
            end
            if (sel_osts) begin
                osts_q <= wdata_i[SMW_CNT_W-1:0];
            end
            rdata_q <= rd_i ? rd_mux : 32'h0000_0000;
        end
    end

    // ****************************************
    // Wake decision and stabilization
    // ****************************************
    smw_wake_dec u_dec (
        .nmi_pin_i(nmi_pin_i),
        .watchdog2_nonmask_irq_i(watchdog2_nonmask_irq_i),
        .ext_pin_irq_i(ext_pin_irq_i),
        .ext_pin_mask_i(ext_pin_mask_i),
        .periph_irq_i(periph_irq_i),
        .periph_prio_i(periph_prio_i),
        .ext_prio_i(ext_prio_i),
        .rst_pin_i(rst_pin_i),
        .watchdog2_reset_i(watchdog2_reset_i),
        .sub_i(sub),
        .psc_i(psc_q),
        .in_isr_i(ctrl_q[SMW_CTRL_IN_ISR]),
        .cur_prio_i(cur_prio_i),
        .w(w)
    );

    // Reset wake uses the reset stabilization length
    assign stab_load = w.reset_wake ? SMW_OSTS_RST : osts_q;
    assign start_stab = stopped & w.wake;

    smw_stab_cnt u_stab (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .start_i(start_stab),
        .load_i(stab_load),
        .done_o(stab_done)
    );

    // Next state: any release restarts the wait
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            SMW_RUN: begin
                if (stop_req) begin
                    state_d = SMW_STOP;
                end
            end
            SMW_STOP: begin
                if (w.wake) begin
                    state_d = SMW_WAIT;
                end
            end
            SMW_WAIT: begin
                if (stab_done) begin
                    state_d = SMW_RUN;
                end
            end
            default: begin
                state_d = SMW_RUN;
            end
        endcase
    end

    // Action the CPU takes once clock returns
    always_comb begin
        if (w.nmi) begin
            act_d = SMW_ACT_NMI;
        end else if (w.ack & irq_globally_enabled_i) begin
            act_d = SMW_ACT_ACK;
        end else begin
            act_d = SMW_ACT_NEXT;
        end
    end

    // ****************************************
    // Peripheral run enables in STOP
    // ****************************************
    assign run_d[0] = ~stopped | (sub & ctrl_q[SMW_CTRL_T16_WT]
        & ctrl_q[SMW_CTRL_WT_SUB]);
    assign run_d[1] = ~stopped | ctrl_q[SMW_CTRL_T8_EXT]
        | (sub & ctrl_q[SMW_CTRL_T8_M16] & ctrl_q[SMW_CTRL_T16_EN]
        & run_d[0]);
    assign run_d[2] = ~stopped | ctrl_q[SMW_CTRL_CSI_EXT];
    assign run_d[3] = ~stopped | ctrl_q[SMW_CTRL_UART_EXT];
    assign run_d[4] = ~stopped;
    assign run_d[5] = ~stopped;
    assign run_d[6] = ~stopped | (ctrl_q[SMW_CTRL_RTO_T8]
        & run_d[1]);
    assign run_d[7] = ~stopped;

    // ****************************************
    // Sequencer and output flops
    // ****************************************
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= SMW_RUN;
            act_q <= SMW_ACT_NONE;
            pend_q <= 1'b0;
            cpu_en_q <= 1'b1;
            sysrst_q <= 1'b1;
            port_q <= 8'h00;
            run_q <= 8'hFF;
        end else begin
            state_q <= state_d;
            cpu_en_q <= (state_d == SMW_RUN);
            sysrst_q <= stopped & w.reset_wake;
            run_q <= run_d;
            // Pins follow the CPU only while running
            if (!stopped) begin
                port_q <= port_out_i;
            end
            if (start_stab) begin
                act_q <= act_d;
                // A maskable wake not acknowledged keeps its request unless an NMI or reset wake comes with it,
                // including one refused because interrupts are disabled
                pend_q <= (act_d == SMW_ACT_NEXT) & ~w.reset_wake;
            end else if (state_q == SMW_RUN && !stop_req) begin
                // Cleared by the CPU's next STOP entry
                act_q <= act_q;
            end
            if (stop_req) begin
                act_q <= SMW_ACT_NONE;
                pend_q <= 1'b0;
            end
        end
    end

    // RAM writes blocked while halted keep data intact
    assign ram_we_en_o = cpu_en_q;
    assign rdata_o = rdata_q;
    assign cpu_clk_en_o = cpu_en_q;
    assign sys_reset_o = sysrst_q;
    assign wake_act_o = act_q;
    assign irq_pending_o = pend_q;
    assign port_pin_o = port_q;
    assign timer16_run_o = run_q[0];
    assign timer8_run_o = run_q[1];
    assign clocked_serial_port_run_o = run_q[2];
    assign first_uart_run_o = run_q[3];
    assign second_uart_run_o = run_q[4];
    assign two_wire_port_run_o = run_q[5];
    assign rto_run_o = run_q[6];
    assign rto_buffer_load_en_o = run_q[7];
endmodule

// ### rtl/smw_wake_dec.sv
// Wake source decoder: qualifies requests against disables and priority
`timescale 1ns/1ps
module smw_wake_dec
    import smw_pkg::*;
(
    // Requests
    input wire logic nmi_pin_i,
    input wire logic watchdog2_nonmask_irq_i,
    input wire logic [7:0] ext_pin_irq_i,
    input wire logic [7:0] ext_pin_mask_i,
    input wire logic periph_irq_i,
    input wire logic [3:0] periph_prio_i,
    input wire logic [3:0] ext_prio_i,
    input wire logic rst_pin_i,
    input wire logic watchdog2_reset_i,
    // Context
    input wire logic sub_i,
    input wire logic [2:0] psc_i,
    input wire logic in_isr_i,
    input wire logic [3:0] cur_prio_i,
    // Decision
    smw_wake_if.src w
);
    wire logic wdt_nm;
    wire logic pin_nm;
    wire logic ext_any;
    wire logic mask_req;
    wire logic ext_hi;
    wire logic per_hi;

    // Second watchdog only counts while on subclock
    assign wdt_nm = watchdog2_nonmask_irq_i & sub_i
        & ~psc_i[SMW_PSC_WDT_NM];
    assign pin_nm = nmi_pin_i & ~psc_i[SMW_PSC_PIN_NM];
    assign ext_any = |(ext_pin_irq_i & ~ext_pin_mask_i);
    // Priority never gates the wake itself
    assign mask_req = (ext_any | periph_irq_i)
        & ~psc_i[SMW_PSC_MASK];
    // Lower value means higher priority
    assign ext_hi = ext_any & (ext_prio_i < cur_prio_i);
    assign per_hi = periph_irq_i & (periph_prio_i < cur_prio_i);

    assign w.nmi = wdt_nm | pin_nm;
    assign w.reset_wake = rst_pin_i | (watchdog2_reset_i & sub_i);
    assign w.wake = w.nmi | mask_req | w.reset_wake;
    // Outside a service routine any unmasked request may be taken
    assign w.ack = mask_req & (~in_isr_i | ext_hi | per_hi);
endmodule

// ### rtl/smw_wake_if.sv
// Interface: wake decision between decoder and sequencer
`timescale 1ns/1ps
interface smw_wake_if;
    import smw_pkg::*;
    logic wake;
    logic nmi;
    logic ack;
    logic reset_wake;
    modport src (output wake, output nmi, output ack, output reset_wake);
    modport dst (input wake, input nmi, input ack, input reset_wake);
endinterface

// ### tb/smw_cpu_model.sv
// Model: CPU core side that feeds the port value
`timescale 1ns/1ps
module smw_cpu_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Port value written by the CPU
    output logic [7:0] port_out_o
);
    // Keeps moving even while halted, so a leak past the freeze shows
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            port_out_o <= 8'h5a;
        end else begin
            port_out_o <= port_out_o + 8'h01;
        end
    end
endmodule

// ### tb/smw_top_checker.sv
// Checker: port assertions of the STOP wake-up controller
`timescale 1ns/1ps
module smw_top_checker
    import smw_pkg::*;
(
    // Clock, reset, register writes
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    // Watched outputs
    input logic cpu_clk_en_o,
    input logic sys_reset_o,
    input logic [1:0] wake_act_o,
    input logic irq_pending_o,
    input logic [7:0] port_pin_o,
    input logic ram_we_en_o,
    input logic timer16_run_o,
    input logic second_uart_run_o,
    input logic two_wire_port_run_o,
    input logic rto_buffer_load_en_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    logic [10:0] ctrl_q;
    // Shadow of the control word, only the subclock bit is used
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl_q <= SMW_CTRL_RST;
        end else if (wr_i && addr_i == SMW_ADDR_CTRL) begin
            ctrl_q <= wdata_i[10:0];
        end
    end
    // Two cycles asleep, so registered outputs have settled
    sequence slept;
        !cpu_clk_en_o ##1 !cpu_clk_en_o;
    endsequence
    ram_we_a: assert property (ram_we_en_o == cpu_clk_en_o)
        else $error("RAM write enable differs from CPU clock enable");
    port_hold_a: assert property (slept |-> $stable(port_pin_o))
        else $error("port pins moved while asleep");
    rto_buf_a: assert property (slept |-> !rto_buffer_load_en_o)
        else $error("output buffer reload allowed while asleep");
    serial_off_a: assert property (slept |->
        !second_uart_run_o && !two_wire_port_run_o)
        else $error("stopped serial port still running");
    t16_off_a: assert property ((!cpu_clk_en_o &&
        !ctrl_q[SMW_CTRL_SUB]) ##1 !cpu_clk_en_o |-> !timer16_run_o)
        else $error("timer16 runs asleep without subclock");
    rst_pulse_a: assert property ($rose(sys_reset_o) |=> !sys_reset_o)
        else $error("system reset pulse longer than one cycle");
    act_hold_a: assert property (cpu_clk_en_o && !wr_i |=>
        $stable(wake_act_o))
        else $error("wake action changed while running");
    gate_min_a: assert property ($fell(cpu_clk_en_o) |->
        !cpu_clk_en_o [*3])
        else $error("CPU clock back before stabilization");
    // Main scenarios reached
    cover property ($fell(cpu_clk_en_o));
    cover property (wake_act_o == SMW_ACT_NMI);
    cover property (irq_pending_o);
    cover property ($rose(sys_reset_o));
endmodule
bind smw_top smw_top_checker i_chk (.clk_i(clk_i), .reset_i(reset_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .cpu_clk_en_o(cpu_clk_en_o), .sys_reset_o(sys_reset_o),
    .wake_act_o(wake_act_o), .irq_pending_o(irq_pending_o),
    .port_pin_o(port_pin_o), .ram_we_en_o(ram_we_en_o),
    .timer16_run_o(timer16_run_o), .second_uart_run_o(second_uart_run_o),
    .two_wire_port_run_o(two_wire_port_run_o),
    .rto_buffer_load_en_o(rto_buffer_load_en_o));

// ### tb/tb.sv
// Testbench: register access and STOP wake scenarios
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin \
    miscompares++; $display("wrong value at %0t: %h not %h", \
    $time, g, e); end end
module tb;
    import smw_pkg::*;
    localparam int OSTS_N = 16;
    localparam int RST_N = 32768;
    // Case word: src, in-ISR, subclock, enable, prio, action, pending
    localparam logic [11:0] CASES [5] = '{12'h206, 12'h586, 12'hab3,
        12'ha94, 12'hc13};
    int n_checks = 0, miscompares = 0;
    logic clk_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
    logic [7:0] addr_i = 8'h00, ext_pin_irq_i = 8'h00;
    logic [7:0] ext_pin_mask_i = 8'h00, port_out_i, port_pin_o;
    logic [31:0] wdata_i = 32'h0000_0000, rdata_o;
    logic nmi_pin_i = 1'b0, watchdog2_nonmask_irq_i = 1'b0;
    logic periph_irq_i = 1'b0, rst_pin_i = 1'b0;
    logic watchdog2_reset_i = 1'b0, irq_globally_enabled_i = 1'b0;
    logic [3:0] periph_prio_i = 4'h0, ext_prio_i = 4'h0;
    logic [3:0] cur_prio_i = 4'h4;
    logic [1:0] wake_act_o;
    logic cpu_clk_en_o, sys_reset_o, irq_pending_o, ram_we_en_o;
    logic timer16_run_o, timer8_run_o, clocked_serial_port_run_o;
    logic first_uart_run_o, second_uart_run_o, two_wire_port_run_o;
    logic rto_run_o, rto_buffer_load_en_o;
    smw_top i_dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .nmi_pin_i(nmi_pin_i),
        .watchdog2_nonmask_irq_i(watchdog2_nonmask_irq_i),
        .ext_pin_irq_i(ext_pin_irq_i), .ext_pin_mask_i(ext_pin_mask_i),
        .periph_irq_i(periph_irq_i), .periph_prio_i(periph_prio_i),
        .ext_prio_i(ext_prio_i), .rst_pin_i(rst_pin_i),
        .watchdog2_reset_i(watchdog2_reset_i),
        .irq_globally_enabled_i(irq_globally_enabled_i),
        .cur_prio_i(cur_prio_i), .port_out_i(port_out_i),
        .cpu_clk_en_o(cpu_clk_en_o), .sys_reset_o(sys_reset_o),
        .wake_act_o(wake_act_o), .irq_pending_o(irq_pending_o),
        .port_pin_o(port_pin_o), .ram_we_en_o(ram_we_en_o),
        .timer16_run_o(timer16_run_o), .timer8_run_o(timer8_run_o),
        .clocked_serial_port_run_o(clocked_serial_port_run_o),
        .first_uart_run_o(first_uart_run_o),
        .second_uart_run_o(second_uart_run_o),
        .two_wire_port_run_o(two_wire_port_run_o),
        .rto_run_o(rto_run_o), .rto_buffer_load_en_o(rto_buffer_load_en_o));
    smw_cpu_model i_cpu (.clk_i(clk_i), .reset_i(reset_i),
        .port_out_o(port_out_i));
    // 40 MHz clock
    always #12.5 clk_i = ~clk_i;
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(posedge clk_i);
        `CHK(rdata_o, e)
    endtask
    task automatic drop();
        @(posedge clk_i);
        nmi_pin_i <= 1'b0;
        watchdog2_nonmask_irq_i <= 1'b0;
        ext_pin_irq_i <= 8'h00;
        periph_irq_i <= 1'b0;
        rst_pin_i <= 1'b0;
        watchdog2_reset_i <= 1'b0;
    endtask
    task automatic raise(input logic [1:0] s, input logic [3:0] p);
        @(posedge clk_i);
        ext_prio_i <= p;
        periph_prio_i <= p;
        nmi_pin_i <= (s == 2'd0);
        watchdog2_nonmask_irq_i <= (s == 2'd1);
        ext_pin_irq_i <= (s == 2'd2) ? 8'h08 : 8'h00;
        periph_irq_i <= (s == 2'd3);
    endtask
    task automatic sleep(input logic [10:0] c);
        wr(SMW_ADDR_CTRL, {21'h0, c | 11'h001});
        repeat (4) @(posedge clk_i);
        `CHK(cpu_clk_en_o, 1'b0)
    endtask
    // Bounded wait for the CPU clock; the window allows two edges of slack
    task automatic wait_run(input int lo, input int hi, input logic rx);
        int n;
        logic rs;
        n = 0;
        rs = 1'b0;
        while (cpu_clk_en_o !== 1'b1 && n <= hi) begin
            drop();
            rs = rs | sys_reset_o;
            n++;
        end
        `CHK(n >= lo && n <= hi, 1'b1)
        `CHK(rs, rx)
    endtask
    // Reset for six cycles
    initial begin
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
    end
    // Watchdog sized well past the two long reset waits
    initial begin
        #(80000 * 25);
        miscompares++;
        print_verdict();
    end
    initial begin
        logic [11:0] c;
        logic [7:0] pv;
        @(negedge reset_i);
        rd(SMW_ADDR_OSTS, {16'h0000, SMW_OSTS_RST});
        rd(SMW_ADDR_PSC, 32'h0000_0000);
        rd(8'h14, 32'h0000_0000);
        wr(SMW_ADDR_OSTS, 32'(OSTS_N));
        rd(SMW_ADDR_OSTS, 32'(OSTS_N));
        $display("test registers done");
        for (int i = 0; i < 5; i++) begin
            c = CASES[i];
            irq_globally_enabled_i <= c[7];
            sleep(c[9] ? 11'h400 : (c[8] ? 11'h3de : 11'h000));
            `CHK(timer16_run_o, c[8])
            `CHK(timer8_run_o, c[8])
            `CHK(clocked_serial_port_run_o, c[8])
            `CHK(first_uart_run_o, c[8])
            `CHK(rto_run_o, c[8])
            pv = port_pin_o;
            raise(c[11:10], c[6:3]);
            drop();
            repeat (6) @(posedge clk_i);
            `CHK(port_pin_o, pv)
            raise(c[11:10], c[6:3]);
            wait_run(OSTS_N + 2, OSTS_N + 4, 1'b0);
            `CHK(wake_act_o, c[2:1])
            `CHK(irq_pending_o, c[0])
            $display("test wake case %0d done", i);
        end
        ext_pin_mask_i <= 8'h08;
        wr(SMW_ADDR_PSC, 32'h0000_0007);
        sleep(11'h000);
        raise(2'd0, 4'h0);
        raise(2'd1, 4'h0);
        raise(2'd2, 4'h0);
        repeat (40) @(posedge clk_i);
        `CHK(cpu_clk_en_o, 1'b0)
        drop();
        $display("test disabled sources done");
        for (int k = 0; k < 2; k++) begin
            if (k == 1) begin
                sleep(11'h002);
            end
            @(posedge clk_i);
            rst_pin_i <= (k == 0);
            watchdog2_reset_i <= (k == 1);
            wait_run(RST_N + 2, RST_N + 4, 1'b1);
            $display("test reset wake %0d done", k);
        end
        print_verdict();
    end
endmodule
